// ---- data_clock_output_gating.sv ----
// data output clock generation with calibration trim gating and apb registers
//
// Chosen here: register access over APB.
`default_nettype none
// Functional notes
// - demux with single data rate: output clock runs at half the sample clock.
// - demux with double data rate: output clock runs at a quarter of it.
// - by default the output clock stops during the termination trim phase.
// - trim-skip bit in register 9h set omits the trim phase from calibrations.
// - the power-on calibration always trims; the skip affects later ones only.
// - data words launch synchronously with the output clock.
module data_clock_output_gating
	import data_output_clock_pos_pkg::*;
#(
	parameter int TRIM_LEN = TRIM_CYCLES,
	parameter int CORE_LEN = CORE_CYCLES
)(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        clkEn,
	// sample clock from outside
	input  wire logic        sampleClk,
	// calibration request from converter core
	input  wire logic        calReq,
	// data word to launch
	input  wire logic [15:0] dataIn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// link outputs
	output diff_pair_s       dataOutputClock,
	output logic [15:0]      dataOut,
	output logic             calBusy
);
	// refuse phase lengths that the counters cannot serve
	if (TRIM_LEN < 1 || CORE_LEN < 1) begin : g_bad_len
		$error("lengths must be at least one");
	end

	typedef struct packed {
		logic [2:0]  smp;
		logic [15:0] extCfg;
		logic [1:0]  mode;
		logic        powerOnDone;
		cal_state_e  cal;
		logic [31:0] cnt;
		logic [31:0] rdata;
		logic        gate;
		logic [15:0] dout;
		diff_pair_s  pair;
	} top_s;

	top_s st_r;
	top_s st_nxt;
	logic dclkLevel;
	logic launch;
	logic sampleEdge;
	logic wrEn;
	logic rdEn;
	logic hit;
	clk_cfg_s cfg;

	assign sampleEdge = st_r.smp[1] & ~st_r.smp[2];
	assign cfg.demux  = st_r.mode[DEMUX_POS];
	assign cfg.ddr    = st_r.mode[DDR_POS];
	assign cfg.trimSkip = st_r.extCfg[TRIM_SKIP_POS];
	assign wrEn = psel & penable & pwrite;
	assign rdEn = psel & ~penable & ~pwrite;
	assign hit  = (paddr == EXT_CFG_OFFSET) || (paddr == CAL_CTRL_OFFSET) ||
		(paddr == STATUS_OFFSET) || (paddr == MODE_OFFSET);

	data_output_clock_pos_divider u_div (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.clkEn      (clkEn),
		.sampleEdge (sampleEdge),
		.cfg        (cfg),
		.gate       (st_r.gate),
		.dclkLevel  (dclkLevel),
		.launch     (launch)
	);

	always_comb begin
		logic calStart;
		calStart = 1'b0;
		st_nxt = st_r;
		st_nxt.smp = {st_r.smp[1:0], sampleClk};
		if (wrEn && paddr == EXT_CFG_OFFSET) begin
			st_nxt.extCfg = pwdata[15:0];
		end
		if (wrEn && paddr == MODE_OFFSET) begin
			st_nxt.mode = pwdata[1:0];
		end
		calStart = calReq || (wrEn && paddr == CAL_CTRL_OFFSET && pwdata[0]);
		unique case (st_r.cal)
			CAL_IDLE: begin
				if (!st_r.powerOnDone || calStart) begin
					st_nxt.cnt = '0;
					// first calibration trims regardless of the skip bit
					if (!st_r.powerOnDone || !cfg.trimSkip) begin
						st_nxt.cal = CAL_TRIM;
					end else begin
						st_nxt.cal = CAL_CORE;
					end
				end
			end
			CAL_TRIM: begin
				st_nxt.cnt = st_r.cnt + 32'h1;
				if (st_r.cnt >= 32'(TRIM_LEN - 1)) begin
					st_nxt.cnt = '0;
					st_nxt.cal = CAL_CORE;
				end
			end
			CAL_CORE: begin
				st_nxt.cnt = st_r.cnt + 32'h1;
				if (st_r.cnt >= 32'(CORE_LEN - 1)) begin
					st_nxt.cal = CAL_DONE;
				end
			end
			CAL_DONE: begin
				st_nxt.powerOnDone = 1'b1;
				st_nxt.cal = CAL_IDLE;
			end
			default: begin
				st_nxt.cal = CAL_IDLE;
			end
		endcase
		st_nxt.gate = (st_nxt.cal == CAL_TRIM);
		if (launch) begin
			st_nxt.dout = dataIn;
		end
		st_nxt.pair.pos = dclkLevel;
		st_nxt.pair.neg = ~dclkLevel;
		if (rdEn) begin
			unique case (paddr)
				EXT_CFG_OFFSET: st_nxt.rdata = {16'h0000, st_r.extCfg};
				MODE_OFFSET:    st_nxt.rdata = {30'h0, st_r.mode};
				STATUS_OFFSET:  st_nxt.rdata = {26'h0, st_r.powerOnDone, st_r.gate, st_r.cal};
				default:        st_nxt.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_r <= '{smp: 3'h0, extCfg: EXT_CFG_RESET, mode: MODE_RESET, powerOnDone: 1'b0,
				cal: CAL_IDLE, cnt: 32'h0, rdata: 32'h0, gate: 1'b0, dout: 16'h0000,
				pair: '{pos: 1'b0, neg: 1'b1}};
		end else if (clkEn) begin
			st_r <= st_nxt;
		end
	end

	assign prdata  = st_r.rdata;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign dataOutputClock = st_r.pair;
	assign dataOut = st_r.dout;
	assign calBusy = (st_r.cal != CAL_IDLE);
endmodule
`default_nettype wire

// ---- data_output_clock_pos_pkg.sv ----
// shared constants and types for the data clock output block
`default_nettype none
package data_output_clock_pos_pkg;
	localparam logic [11:0] EXT_CFG_OFFSET   = 12'h024; // index 9h, byte address 4 * index
	localparam logic [11:0] CAL_CTRL_OFFSET  = 12'h040;
	localparam logic [11:0] STATUS_OFFSET    = 12'h044;
	localparam logic [11:0] MODE_OFFSET      = 12'h048;
	localparam int          EXT_CFG_INDEX    = 9;
	localparam int          TRIM_SKIP_POS    = 0;
	localparam int          DEMUX_POS        = 0;
	localparam int          DDR_POS          = 1;
	localparam logic [15:0] EXT_CFG_RESET    = 16'h0000;
	localparam logic [1:0]  MODE_RESET       = 2'h1;
	localparam int          TRIM_TIME_US     = 10;
	localparam int          CLK_MHZ          = 40;
	localparam int          TRIM_CYCLES      = TRIM_TIME_US * CLK_MHZ;
	localparam int          CORE_CYCLES      = 64;

	typedef enum logic [3:0] {
		CAL_IDLE = 4'b0001,
		CAL_TRIM = 4'b0010,
		CAL_CORE = 4'b0100,
		CAL_DONE = 4'b1000
	} cal_state_e;

	typedef struct packed {
		logic       pos;
		logic       neg;
	} diff_pair_s;

	typedef struct packed {
		logic       demux;
		logic       ddr;
		logic       trimSkip;
	} clk_cfg_s;
endpackage
`default_nettype wire

// ---- data_output_clock_pos_divider.sv ----
// divides the sampled sample-clock edges down to the data output clock
`default_nettype none
module data_output_clock_pos_divider
	import data_output_clock_pos_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       clkEn,
	// control
	input  wire logic       sampleEdge,
	input  wire clk_cfg_s   cfg,
	input  wire logic       gate,
	// output
	output logic            dclkLevel,
	output logic            launch
);
	typedef struct packed {
		logic [1:0] cnt;
		logic       level;
		logic       launch;
	} div_s;

	div_s st_r;
	div_s st_nxt;

	always_comb begin
		logic [1:0] wrap;
		wrap = 2'h0;
		st_nxt = st_r;
		st_nxt.launch = 1'b0;
		// toggling every edge gives 1/2 rate, every second edge gives 1/4
		if (!cfg.demux) begin
			wrap = 2'h0;
		end else if (cfg.ddr) begin
			wrap = 2'h1;
		end else begin
			wrap = 2'h0;
		end
		if (gate) begin
			st_nxt.cnt = 2'h0;
		end else if (sampleEdge) begin
			if (st_r.cnt >= wrap) begin
				st_nxt.cnt = 2'h0;
				st_nxt.level = ~st_r.level;
				st_nxt.launch = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + 2'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else if (clkEn) begin
			st_r <= st_nxt;
		end
	end

	assign dclkLevel = st_r.level;
	assign launch    = st_r.launch;
endmodule
`default_nettype wire

// ---- data_output_clock_pos_capture.sv ----
// capture logic model: latches data at each output clock edge
`default_nettype none
module data_output_clock_pos_capture
	import data_output_clock_pos_pkg::*;
(
	// link in
	input  wire logic        ref_clk,
	input  wire diff_pair_s  dataOutputClock,
	input  wire logic [15:0] dataOut,
	// captured
	output logic [15:0]      word,
	output int               edges
);
	timeunit 1ns;
	timeprecision 100ps;
	logic last = 1'h0;
	initial word = 16'h0000;
	initial edges = 0;
	always @(posedge ref_clk) begin
		if (dataOutputClock.pos !== last) begin
			word <= dataOut;
			edges <= edges + 1;
		end
		last <= dataOutputClock.pos;
	end
endmodule
`default_nettype wire

// ---- data_clock_output_gating_asserts.sv ----
// port assertions for the data output clock block
`default_nettype none
module data_clock_output_gating_asserts
	import data_output_clock_pos_pkg::*;
#(
	parameter int TRIM_LEN = TRIM_CYCLES
)(
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// watched
	input wire logic        sampleClk,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire diff_pair_s  dataOutputClock,
	input wire logic [15:0] dataOut,
	input wire logic        calBusy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic scQ, posQ, togQ, skip, ddr, modeW, poDone;
	int upCnt, edges;
	wire tog = dataOutputClock.pos ^ posQ;
	wire wr = psel & penable & pwrite;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			{scQ, posQ, togQ, skip, ddr, poDone} <= '0;
			modeW <= 1'h1;
			upCnt <= 0;
			edges <= 0;
		end else begin
			scQ <= sampleClk;
			posQ <= dataOutputClock.pos;
			togQ <= tog;
			upCnt <= upCnt + int'(upCnt < 999);
			// sample clock edges seen since the last output toggle
			edges <= (tog ? 0 : edges) + int'(sampleClk & !scQ);
			if (wr && paddr == EXT_CFG_OFFSET) skip <= pwdata[TRIM_SKIP_POS];
			if (wr && paddr == MODE_OFFSET) ddr <= pwdata[DDR_POS];
			if (wr && paddr == MODE_OFFSET) modeW <= 1'h1;
			else if (tog) modeW <= 1'h0;
			if ($fell(calBusy)) poDone <= 1'h1;
		end
	end
	sequence s_frozen;
		$stable(dataOutputClock)[*8];
	endsequence
	a_legs_opposite:
		assert property (dataOutputClock.neg != dataOutputClock.pos) else $error("legs equal");
	a_sdr_rate:
		assert property (tog && !modeW && !ddr |-> edges >= 1) else $error("sdr too fast");
	a_ddr_rate:
		assert property (tog && !modeW && ddr |-> edges >= 2) else $error("ddr too fast");
	a_trim_freeze:
		assert property ($rose(calBusy) && !skip |-> ##3 s_frozen) else $error("clock ran in trim");
	a_skip_runs:
		assert property ($rose(calBusy) && skip && poDone |-> ##[1:24] tog) else $error("clock stopped");
	a_poweron_trim:
		assert property (upCnt < TRIM_LEN - 1 |-> $stable(dataOutputClock)) else $error("no first trim");
	a_data_launch:
		assert property ($changed(dataOut) |-> tog || togQ) else $error("data off clock");
endmodule
`default_nettype wire

// ---- tb_data_clock_output_gating.sv ----
// testbench for the data output clock block
`default_nettype none
module tb_data_clock_output_gating import data_output_clock_pos_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'h0, rst = 1'h1, sampleClk = 1'h0, calReq = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, calBusy, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] dataIn = 16'h0000, dataOut, word;
	diff_pair_s dataOutputClock;
	int failures = 0, n_tests = 0, edges, t;
	always #12.5 ref_clk = ~ref_clk;
	always #100 sampleClk = ~sampleClk;
	data_clock_output_gating #(.TRIM_LEN(40), .CORE_LEN(40)) DUT (.ref_clk, .rst, .clkEn(1'h1),
		.sampleClk, .calReq, .dataIn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .dataOutputClock, .dataOut, .calBusy);
	data_output_clock_pos_capture cap (.ref_clk, .dataOutputClock, .dataOut, .word, .edges);
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'h1 && n < 40);
		if (pready !== 1'h1) begin
			failures++;
			$display("[ERR] %0t apb transfer timed out", $time);
			complete_run;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		while (calBusy !== 1'h0 && n < 300) begin
			@(posedge ref_clk);
			n++;
		end
		if (calBusy !== 1'h0) begin
			failures++;
			$display("[ERR] %0t calibration did not finish", $time);
			complete_run;
		end
	endtask
	task automatic count(input int cyc);
		int e0;
		e0 = edges;
		repeat (cyc) @(posedge ref_clk);
		t = edges - e0;
	endtask
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'h0;
		count(30);
		chk(t, 0);
		wait_idle;
		apb(1'h0, EXT_CFG_OFFSET, 32'h0);
		chk(rd, {16'h0000, EXT_CFG_RESET});
		apb(1'h0, MODE_OFFSET, 32'h0);
		chk(rd, {30'h0, MODE_RESET});
		apb(1'h0, 12'h0f0, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		dataIn <= 16'h5a3c;
		count(256);
		chk(t >= 31 && t <= 33, 1);
		chk(word, 16'h5a3c);
		apb(1'h1, MODE_OFFSET, 32'h3);
		dataIn <= 16'hc3a5;
		count(256);
		chk(t >= 15 && t <= 17, 1);
		chk(word, 16'hc3a5);
		calReq <= 1'h1;
		repeat (5) @(posedge ref_clk);
		calReq <= 1'h0;
		count(30);
		chk(t, 0);
		apb(1'h0, STATUS_OFFSET, 32'h0);
		chk(rd, 32'h32);
		wait_idle;
		apb(1'h1, EXT_CFG_OFFSET, 32'h1);
		apb(1'h0, EXT_CFG_OFFSET, 32'h0);
		chk(rd, 32'h1);
		apb(1'h1, CAL_CTRL_OFFSET, 32'h1);
		chk({31'h0, calBusy}, 32'h1);
		count(36);
		chk(t > 1, 1);
		wait_idle;
		apb(1'h1, MODE_OFFSET, 32'h0);
		count(256);
		chk(t >= 31 && t <= 33, 1);
		rst <= 1'h1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'h0;
		apb(1'h1, EXT_CFG_OFFSET, 32'h1);
		count(25);
		chk(t, 0);
		complete_run;
	end
endmodule
bind data_clock_output_gating data_clock_output_gating_asserts #(.TRIM_LEN(TRIM_LEN)) chk_i (.ref_clk, .rst,
	.sampleClk, .psel, .penable, .pwrite, .paddr, .pwdata, .dataOutputClock, .dataOut, .calBusy);
`default_nettype wire
